// file: shared/program_flow_pkg.sv
`default_nettype none
package program_flow_pkg;
    // ==========================================================
    // widths
    localparam int IP_W = 13;
    localparam int LOW_W = 11;
    localparam int PAGE_W = 2;
    localparam int WORD_W = 16;
    localparam int IDX_W = 4;
    localparam int SEL_W = 3;
    localparam int SLOTS = 7;
    localparam int RF_ADDR_W = 7;

    // ==========================================================
    // addresses and reset values
    localparam logic [IP_W-1:0] IP_RESET = 13'h0000;
    localparam logic [IP_W-1:0] VEC_EXT_IRQ = 13'h0005;
    localparam logic [IP_W-1:0] VEC_TIMER = 13'h0003;
    localparam logic [IP_W-1:0] IP_ONE = 13'h0001;
    localparam logic [IP_W-1:0] IP_TWO = 13'h0002;
    localparam logic [PAGE_W-1:0] PAGE_ZERO = 2'h0;
    localparam logic [IDX_W-1:0] IDX_RESET = 4'h7;
    localparam logic [SEL_W-1:0] SEL_ONE = 3'h1;
    localparam logic [SEL_W-1:0] SEL_NONE = 3'h7;
    localparam logic [RF_ADDR_W-1:0] RF_STACK_INDEX = 7'h01;
    // slot bits above the pointer width
    localparam logic [WORD_W-IP_W-1:0] SLOT_HIGH_ZERO = 3'h0;

    // ==========================================================
    // decoder commands
    typedef enum logic [10:0] {
        OP_HOLD = 11'h001,
        OP_NEXT = 11'h002,
        OP_SKIP = 11'h004,
        OP_JUMP_DIRECT = 11'h008,
        OP_CALL_DIRECT = 11'h010,
        OP_JUMP_INDIRECT = 11'h020,
        OP_CALL_INDIRECT = 11'h040,
        OP_TABLE_FETCH = 11'h080,
        OP_SUBROUTINE_EXIT = 11'h100,
        OP_EXIT_AND_SKIP = 11'h200,
        OP_INTERRUPT_EXIT = 11'h400
    } op_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_TABLE_READ = 2'b10
    } phase_t;

    typedef struct packed {
        op_t op;
        logic [PAGE_W-1:0] page;
        logic [LOW_W-1:0] operand;
    } cmd_t;

    typedef struct packed {
        logic write;
        logic [RF_ADDR_W-1:0] addr;
        logic [IDX_W-1:0] wdata;
    } rf_access_t;

    typedef struct packed {
        phase_t phase;
        logic [IP_W-1:0] instruction_pointer;
        logic [IP_W-1:0] fetch_addr;
        logic [IDX_W-1:0] return_stack_index;
        logic [SLOTS-1:0][IP_W-1:0] return_address_slot;
        logic [WORD_W-1:0] table_data_buffer;
    } state_t;
endpackage
`default_nettype wire

// file: hdl/program_flow_and_return_stack.sv
// How it works
// - direct jump loads page bits b12..b11 from page number, low bits from operand.
// - interrupt loads vector 0005H for external pin, else 0003H for timer.
// - power-on and chip-enable resets clear the instruction pointer.
// - calls, table fetches and accepted interrupts store a return address.
// - eight slot positions 0..7, only slots 0..6 have storage.
// - the top three bits of every slot read as zero.
// - stack index is a 4-bit binary counter selecting a slot.
// - software reads and writes the stack index at register address 01H.
// - index low three bits select slot, top bit held at zero.
// - a call decrements the index, then writes the selected slot.
// - returns load the pointer from the selected slot (exit-and-skip adds one), then increment index.
// - table fetch pushes, reads word to buffer, restores pointer, increments index.
// - interrupt acceptance decrements the index, then saves the return address.
// - slot 7 reads as zero at index 07H; nesting stays within seven.
`default_nettype none
module program_flow_and_return_stack (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_reset_in,
    input wire logic clock_stop_reset_in,
    input wire program_flow_pkg::cmd_t cmd_in,
    input wire logic ext_irq_accept_in,
    input wire logic timer_irq_accept_in,
    input wire logic [program_flow_pkg::IP_W-1:0] indirect_pointer_reg_in,
    input wire logic [program_flow_pkg::WORD_W-1:0] prog_data_in,
    input wire program_flow_pkg::rf_access_t rf_in,
    output logic busy_out,
    output logic [program_flow_pkg::IP_W-1:0] instruction_pointer_out,
    output logic [program_flow_pkg::IP_W-1:0] prog_addr_out,
    output logic [program_flow_pkg::WORD_W-1:0] table_data_buffer_out,
    output logic [program_flow_pkg::IDX_W-1:0] rf_rdata_out
);
    // ==========================================================
    // helpers
    // slot 7 has no storage behind it; it reads as zero here
    function automatic logic [program_flow_pkg::IP_W-1:0] read_slot(
        input logic [program_flow_pkg::SLOTS-1:0][program_flow_pkg::IP_W-1:0] slots,
        input logic [program_flow_pkg::SEL_W-1:0] sel
    );
        logic [program_flow_pkg::IP_W-1:0] value;
        value = program_flow_pkg::IP_RESET;
        if (sel != program_flow_pkg::SEL_NONE)
        begin
            value = slots[sel];
        end
        return value;
    endfunction

    function automatic logic [program_flow_pkg::SEL_W-1:0] sel_down(
        input logic [program_flow_pkg::IDX_W-1:0] index
    );
        return index[program_flow_pkg::SEL_W-1:0] - program_flow_pkg::SEL_ONE;
    endfunction

    function automatic logic [program_flow_pkg::IDX_W-1:0] as_index(
        input logic [program_flow_pkg::SEL_W-1:0] sel
    );
        return {1'b0, sel};
    endfunction

    // ==========================================================
    // state
    program_flow_pkg::state_t state;
    program_flow_pkg::state_t next_state;

    logic [program_flow_pkg::SEL_W-1:0] sel;
    logic [program_flow_pkg::SEL_W-1:0] push_sel;
    logic [program_flow_pkg::IP_W-1:0] top_slot;
    logic [program_flow_pkg::IP_W-1:0] ip_plus_one;

    assign sel = state.return_stack_index[program_flow_pkg::SEL_W-1:0];
    assign push_sel = sel_down(state.return_stack_index);
    // slots keep only the 13 pointer bits, so the bits above always read as zero
    assign top_slot = read_slot(state.return_address_slot, sel);
    assign ip_plus_one = state.instruction_pointer + program_flow_pkg::IP_ONE;

    always_comb
    begin
        next_state = state;
        // software write to the index; a hardware stack move in the same cycle wins
        if (rf_in.write && rf_in.addr == program_flow_pkg::RF_STACK_INDEX)
        begin
            next_state.return_stack_index = as_index(rf_in.wdata[program_flow_pkg::SEL_W-1:0]);
        end
        unique case (state.phase)
            program_flow_pkg::ST_TABLE_READ:
            begin
                // the word at the indirect pointer is on prog_data_in now
                next_state.table_data_buffer = prog_data_in;
                next_state.instruction_pointer = top_slot;
                next_state.fetch_addr = top_slot;
                next_state.return_stack_index = as_index(sel + program_flow_pkg::SEL_ONE);
                next_state.phase = program_flow_pkg::ST_RUN;
            end
            program_flow_pkg::ST_RUN:
            begin
                if (ext_irq_accept_in || timer_irq_accept_in)
                begin
                    // the interrupted instruction has not run: resume at it
                    if (push_sel != program_flow_pkg::SEL_NONE)
                    begin
                        next_state.return_address_slot[push_sel] = state.instruction_pointer;
                    end
                    next_state.return_stack_index = as_index(push_sel);
                    next_state.instruction_pointer = ext_irq_accept_in ?
                        program_flow_pkg::VEC_EXT_IRQ : program_flow_pkg::VEC_TIMER;
                end
                else
                begin
                    unique case (cmd_in.op)
                        program_flow_pkg::OP_HOLD:
                        begin
                        end
                        program_flow_pkg::OP_NEXT:
                        begin
                            next_state.instruction_pointer = ip_plus_one;
                        end
                        program_flow_pkg::OP_SKIP:
                        begin
                            next_state.instruction_pointer =
                                state.instruction_pointer + program_flow_pkg::IP_TWO;
                        end
                        program_flow_pkg::OP_JUMP_DIRECT:
                        begin
                            next_state.instruction_pointer =
                                {cmd_in.page, cmd_in.operand};
                        end
                        program_flow_pkg::OP_JUMP_INDIRECT:
                        begin
                            next_state.instruction_pointer = indirect_pointer_reg_in;
                        end
                        program_flow_pkg::OP_CALL_DIRECT,
                        program_flow_pkg::OP_CALL_INDIRECT,
                        program_flow_pkg::OP_TABLE_FETCH:
                        begin
                            if (push_sel != program_flow_pkg::SEL_NONE)
                            begin
                                next_state.return_address_slot[push_sel] = ip_plus_one;
                            end
                            next_state.return_stack_index = as_index(push_sel);
                            if (cmd_in.op == program_flow_pkg::OP_CALL_DIRECT)
                            begin
                                next_state.instruction_pointer =
                                    {program_flow_pkg::PAGE_ZERO, cmd_in.operand};
                            end
                            else if (cmd_in.op == program_flow_pkg::OP_CALL_INDIRECT)
                            begin
                                next_state.instruction_pointer = indirect_pointer_reg_in;
                            end
                            else
                            begin
                                // pointer stays; memory is steered to the table word
                                next_state.fetch_addr = indirect_pointer_reg_in;
                                next_state.phase = program_flow_pkg::ST_TABLE_READ;
                            end
                        end
                        program_flow_pkg::OP_SUBROUTINE_EXIT,
                        program_flow_pkg::OP_INTERRUPT_EXIT:
                        begin
                            next_state.instruction_pointer = top_slot;
                            next_state.return_stack_index =
                                as_index(sel + program_flow_pkg::SEL_ONE);
                        end
                        program_flow_pkg::OP_EXIT_AND_SKIP:
                        begin
                            next_state.instruction_pointer =
                                top_slot + program_flow_pkg::IP_ONE;
                            next_state.return_stack_index =
                                as_index(sel + program_flow_pkg::SEL_ONE);
                        end
                        default:
                        begin
                        end
                    endcase
                end
                if (next_state.phase == program_flow_pkg::ST_RUN)
                begin
                    next_state.fetch_addr = next_state.instruction_pointer;
                end
            end
            default:
            begin
                next_state.phase = program_flow_pkg::ST_RUN;
            end
        endcase
        // resets override the index, phase and fetch address; clock-stop leaves the pointer alone
        if (rst_in || ce_reset_in || clock_stop_reset_in)
        begin
            next_state.return_stack_index = program_flow_pkg::IDX_RESET;
            next_state.phase = program_flow_pkg::ST_RUN;
            next_state.fetch_addr = next_state.instruction_pointer;
        end
        if (rst_in || ce_reset_in)
        begin
            next_state.instruction_pointer = program_flow_pkg::IP_RESET;
            next_state.fetch_addr = program_flow_pkg::IP_RESET;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state.phase <= program_flow_pkg::ST_RUN;
            state.instruction_pointer <= program_flow_pkg::IP_RESET;
            state.fetch_addr <= program_flow_pkg::IP_RESET;
            state.return_stack_index <= program_flow_pkg::IDX_RESET;
            state.return_address_slot <= '0;
            state.table_data_buffer <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ==========================================================
    // outputs
    assign busy_out = (state.phase == program_flow_pkg::ST_TABLE_READ);
    assign instruction_pointer_out = state.instruction_pointer;
    assign prog_addr_out = state.fetch_addr;
    assign table_data_buffer_out = state.table_data_buffer;
    assign rf_rdata_out = as_index(sel);

endmodule
`default_nettype wire

// file: sim/flow_checker.sv
`default_nettype none
module flow_checker (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_reset_in,
    input wire logic clock_stop_reset_in,
    input wire program_flow_pkg::cmd_t cmd_in,
    input wire logic ext_irq_accept_in,
    input wire logic timer_irq_accept_in,
    input wire logic [12:0] indirect_pointer_reg_in,
    input wire logic [15:0] prog_data_in,
    input wire logic busy_out,
    input wire logic [12:0] instruction_pointer_out,
    input wire logic [12:0] prog_addr_out,
    input wire logic [15:0] table_data_buffer_out,
    input wire logic [3:0] rf_rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // helpers: a command counts only when no irq, reset or busy cycle overrides it
    default clocking dc @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire logic [12:0] ip = instruction_pointer_out;
    wire logic [12:0] tgt = {cmd_in.page, cmd_in.operand};
    wire logic [12:0] low = {2'h0, cmd_in.operand};
    wire logic [2:0] idx = rf_rdata_out[2:0];
    wire logic ok = !busy_out && !ce_reset_in && !clock_stop_reset_in;
    wire logic go = ok && !ext_irq_accept_in && !timer_irq_accept_in;
    wire logic jd = go && cmd_in.op == program_flow_pkg::OP_JUMP_DIRECT;
    wire logic cd = go && cmd_in.op == program_flow_pkg::OP_CALL_DIRECT;
    wire logic ji = go && cmd_in.op == program_flow_pkg::OP_JUMP_INDIRECT;
    wire logic ci = go && cmd_in.op == program_flow_pkg::OP_CALL_INDIRECT;
    wire logic rt = go && cmd_in.op == program_flow_pkg::OP_SUBROUTINE_EXIT;
    wire logic tf = go && cmd_in.op == program_flow_pkg::OP_TABLE_FETCH;

    // ==========================================================
    // properties
    a_jump_direct: assert property (jd |=> ip == $past(tgt))
        else $error("direct jump target wrong");
    a_call_page_zero: assert property (cd |=> ip == $past(low) && idx == $past(idx) - 3'h1)
        else $error("direct call target or index wrong");
    a_indirect_target: assert property ((ji || ci) |=> ip == $past(indirect_pointer_reg_in))
        else $error("indirect target wrong");
    a_ext_vector: assert property (ext_irq_accept_in && ok |=> ip == 13'h0005 && idx == $past(idx) - 3'h1)
        else $error("external vector or index wrong");
    a_timer_vector: assert property (timer_irq_accept_in && !ext_irq_accept_in && ok |=> ip == 13'h0003)
        else $error("timer vector wrong");
    a_ce_clear: assert property (ce_reset_in |=> ip == 13'h0000 && rf_rdata_out == 4'h7)
        else $error("chip-enable reset values wrong");
    a_stop_index: assert property (clock_stop_reset_in |=> rf_rdata_out == 4'h7)
        else $error("clock-stop index wrong");
    a_index_msb: assert property (rf_rdata_out[3] == 1'b0)
        else $error("index msb not zero");
    a_call_return: assert property (cd ##1 rt |=> ip == $past(ip, 2) + 13'h1 && idx == $past(idx, 2))
        else $error("return did not restore caller");
    a_table_walk: assert property (tf |=> busy_out && prog_addr_out == $past(indirect_pointer_reg_in)
        ##1 !busy_out && table_data_buffer_out == $past(prog_data_in) && ip == $past(ip, 2) + 13'h1)
        else $error("table fetch sequence wrong");
endmodule

bind program_flow_and_return_stack flow_checker u_chk (
    .clk_in(clk_in), .rst_in(rst_in), .ce_reset_in(ce_reset_in),
    .clock_stop_reset_in(clock_stop_reset_in), .cmd_in(cmd_in),
    .ext_irq_accept_in(ext_irq_accept_in), .timer_irq_accept_in(timer_irq_accept_in),
    .indirect_pointer_reg_in(indirect_pointer_reg_in), .prog_data_in(prog_data_in),
    .busy_out(busy_out), .instruction_pointer_out(instruction_pointer_out),
    .prog_addr_out(prog_addr_out), .table_data_buffer_out(table_data_buffer_out),
    .rf_rdata_out(rf_rdata_out)
);
`default_nettype wire

// file: sim/prog_mem_model.sv
`default_nettype none
module prog_mem_model (
    input wire logic [12:0] addr_in,
    output logic [15:0] data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // word tied to its address so table reads are predictable
    always_comb
    begin
        // no memory in the hole: return garbage rather than a plausible word
        if (addr_in >= 13'h1EFC)
            data_out = ~{3'h5, addr_in};
        else
            data_out = {3'h5, addr_in};
    end
endmodule
`default_nettype wire

// file: sim/tb_program_flow_and_return_stack.sv
`default_nettype none
module tb_program_flow_and_return_stack;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in, rst_in, ce, cs, ext, tmr, busy;
    program_flow_pkg::cmd_t cmd;
    program_flow_pkg::rf_access_t rf;
    logic [12:0] iptr, ip, paddr;
    logic [15:0] pdata, dbuf;
    logic [3:0] idx;
    int fail_count = 0;
    int total_checks = 0;

    program_flow_and_return_stack u_dut (
        .clk_in(clk_in), .rst_in(rst_in), .ce_reset_in(ce), .clock_stop_reset_in(cs),
        .cmd_in(cmd), .ext_irq_accept_in(ext), .timer_irq_accept_in(tmr),
        .indirect_pointer_reg_in(iptr), .prog_data_in(pdata), .rf_in(rf), .busy_out(busy),
        .instruction_pointer_out(ip), .prog_addr_out(paddr), .table_data_buffer_out(dbuf),
        .rf_rdata_out(idx));
    prog_mem_model u_mem (.addr_in(paddr), .data_out(pdata));

    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // ==========================================================
    // shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d errors=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // command stays up until the next call, so two calls run back to back
    task automatic op(input program_flow_pkg::op_t o, input logic [12:0] a);
        @(negedge clk_in);
        cmd = '{o, a[12:11], a[10:0]};
    endtask

    task automatic run(input program_flow_pkg::op_t o, input logic [12:0] a);
        op(o, a);
        op(program_flow_pkg::OP_HOLD, 13'h0000);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_jumps();
        for (int p = 0; p < 4; p++)
        begin
            run(program_flow_pkg::OP_JUMP_DIRECT, {p[1:0], 11'h3A5});
            chk(ip, {p[1:0], 11'h3A5});
        end
        run(program_flow_pkg::OP_CALL_DIRECT, 13'h1955);
        chk(ip, 13'h0155);
        chk(idx, 4'h6);
        op(program_flow_pkg::OP_CALL_DIRECT, 13'h0200);
        op(program_flow_pkg::OP_SUBROUTINE_EXIT, 13'h0000);
        run(program_flow_pkg::OP_SUBROUTINE_EXIT, 13'h0000);
        chk(ip, 13'h1BA6);
        chk(idx, 4'h7);
    endtask

    task automatic t_indirect();
        iptr = 13'h0ABC;
        run(program_flow_pkg::OP_JUMP_INDIRECT, 13'h0000);
        chk(ip, 13'h0ABC);
        iptr = 13'h0040;
        run(program_flow_pkg::OP_CALL_INDIRECT, 13'h0000);
        chk(ip, 13'h0040);
        chk(idx, 4'h6);
        run(program_flow_pkg::OP_EXIT_AND_SKIP, 13'h0000);
        chk(ip, 13'h0ABE);
        chk(idx, 4'h7);
    endtask

    task automatic t_table();
        iptr = 13'h0123;
        op(program_flow_pkg::OP_TABLE_FETCH, 13'h0000);
        op(program_flow_pkg::OP_JUMP_DIRECT, 13'h0777);
        chk(busy, 1'b1);
        chk(paddr, 13'h0123);
        chk(idx, 4'h6);
        op(program_flow_pkg::OP_HOLD, 13'h0000);
        chk(dbuf, 16'hA123);
        chk(ip, 13'h0ABF);
        chk(idx, 4'h7);
    endtask

    task automatic t_irq();
        op(program_flow_pkg::OP_JUMP_DIRECT, 13'h0111);
        ext = 1'b1;
        op(program_flow_pkg::OP_HOLD, 13'h0000);
        ext = 1'b0;
        chk(ip, 13'h0005);
        chk(idx, 4'h6);
        run(program_flow_pkg::OP_INTERRUPT_EXIT, 13'h0000);
        chk(ip, 13'h0ABF);
        @(negedge clk_in);
        ext = 1'b1;
        tmr = 1'b1;
        @(negedge clk_in);
        ext = 1'b0;
        chk(ip, 13'h0005);
        @(negedge clk_in);
        tmr = 1'b0;
        chk(ip, 13'h0003);
        chk(idx, 4'h5);
    endtask

    task automatic t_regs();
        @(negedge clk_in);
        rf = '{1'b1, 7'h01, 4'hA};
        @(negedge clk_in);
        rf.write = 1'b0;
        chk(idx, 4'h2);
        cs = 1'b1;
        @(negedge clk_in);
        cs = 1'b0;
        chk(idx, 4'h7);
        chk(ip, 13'h0003);
        ce = 1'b1;
        @(negedge clk_in);
        ce = 1'b0;
        chk(ip, 13'h0000);
        chk(idx, 4'h7);
        run(program_flow_pkg::OP_NEXT, 13'h0000);
        chk(ip, 13'h0001);
        run(program_flow_pkg::OP_SKIP, 13'h0000);
        chk(ip, 13'h0003);
    endtask

    task automatic t_nest();
        for (int i = 0; i < 7; i++)
            run(program_flow_pkg::OP_CALL_DIRECT, 13'(13'h0100 + i));
        chk(idx, 4'h0);
        for (int i = 6; i >= 0; i--)
        begin
            run(program_flow_pkg::OP_SUBROUTINE_EXIT, 13'h0000);
            chk(ip, (i == 0) ? 13'h0004 : 13'(13'h0100 + i));
        end
        chk(idx, 4'h7);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        summarize();
    end

    initial
    begin
        {rst_in, ce, cs, ext, tmr} = 5'h10;
        iptr = 13'h0000;
        rf = '0;
        cmd = '{program_flow_pkg::OP_HOLD, 2'h0, 11'h000};
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 1'b0;
        chk(ip, 13'h0000);
        chk(idx, 4'h7);
        chk(busy, 1'h0);
        chk(dbuf, 16'h0000);
        t_jumps();
        t_indirect();
        t_table();
        t_irq();
        t_regs();
        t_nest();
        summarize();
    end
endmodule
`default_nettype wire
